// ===== bench/apb_host_model.sv
`timescale 1ns/100ps
`include "pad_cfg_defs.svh"

// processor side of the peripheral bus, driven through xfer
module apb_host_model (
    output logic psel,
    output logic penable,
    output logic pwrite,
    output pad_cfg_pkg::addr_t paddr,
    output pad_cfg_pkg::word_t pwdata,
    output pad_cfg_pkg::strb_t pstrb,
    output pad_cfg_pkg::prot_t pprot,
    input wire logic pclk,
    input wire pad_cfg_pkg::word_t prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import pad_cfg_pkg::*;

    // bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'hFFF;
        pwdata = 32'h0;
        pstrb = 4'h0;
        pprot = 3'h0;
    end

    // one transfer; the request holds until pready is sampled high
    task automatic xfer(input logic w, input addr_t a, input word_t d, input strb_t s, input prot_t p,
                        output word_t rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= (w && a == `ADDR_TEST) ? 32'h0 : d;
        pstrb <= s;
        pprot <= p;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle count assumed; only the bench watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        // released select, address, data and strobe lines must not keep the old value; pwrite and pprot stay as they were
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        pstrb <= ~s;
    endtask : xfer
endmodule : apb_host_model

// ===== bench/chip_pad_config_regs_tb_top.sv
`timescale 1ns/100ps
`include "pad_cfg_defs.svh"

module chip_pad_config_regs_tb_top;
    import pad_cfg_pkg::*;
    localparam logic [7:0] ID_VAL = 8'hC3; // arbitrary value
    localparam logic [7:0] REV_VAL = 8'h07; // arbitrary value
    localparam word_t RSV_MASK = 32'hDFF0FFFF;
    localparam logic WR = 1'b1;
    localparam logic RD = 1'b0;
    localparam prot_t SUP = 3'h1;
    localparam prot_t USR = 3'h0;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    addr_t paddr;
    word_t pwdata, prdata, slew_limit_bits, pulldown_enable_bits, rd;
    strb_t pstrb;
    prot_t pprot;
    logic [15:0] factory_test_reg;
    int err_count = 0;
    int cmp_count = 0;

    chip_pad_config_regs #(.PART_ID(ID_VAL), .PART_REV(REV_VAL)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slew_limit_bits(slew_limit_bits), .pulldown_enable_bits(pulldown_enable_bits),
        .factory_test_reg(factory_test_reg));

    apb_host_model u_host (
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pprot(pprot), .pclk(pclk), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // free-running clock
    initial pclk = 1'b0;
    always #5 pclk = ~pclk;

    task automatic check(input string name, input word_t seen, input word_t exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // every read is judged; a refused read must come back as zero
    task automatic acc(input logic w, input addr_t a, input word_t d, input strb_t s, input prot_t p,
                       input word_t exp, input logic exp_err);
        u_host.xfer(w, a, d, s, p, rd, err);
        check($sformatf("error flag at %h", a), {31'h0, err}, {31'h0, exp_err});
        if (!w) check($sformatf("read data at %h", a), rd, exp);
    endtask : acc

    task automatic test_reset_values;
        check("slew out", slew_limit_bits, 32'h0);
        check("pull out", pulldown_enable_bits, 32'h0);
        check("test out", {16'h0, factory_test_reg}, 32'h0);
        acc(RD, `ADDR_SLEW, 32'h0, 4'hF, SUP, 32'h0, 1'b0);
        acc(RD, `ADDR_PULL, 32'h0, 4'hF, SUP, 32'h0, 1'b0);
        acc(RD, `ADDR_TEST, 32'h0, 4'hF, SUP, 32'h0, 1'b0);
        acc(RD, `ADDR_IDENT, 32'h0, 4'hF, SUP, {16'h0, ID_VAL, REV_VAL}, 1'b0);
        $display("test reset_values done");
    endtask : test_reset_values

    // all ones, then a lane-0-only write, then a full write touching bit 29
    task automatic test_pin_field(input addr_t a, input bit pull);
        acc(WR, a, 32'hFFFFFFFF, 4'hF, SUP, 32'h0, 1'b0);
        acc(RD, a, 32'h0, 4'hF, SUP, RSV_MASK, 1'b0);
        check("pin out", pull ? pulldown_enable_bits : slew_limit_bits, RSV_MASK);
        acc(WR, a, 32'h00004001, 4'h1, SUP, 32'h0, 1'b0);
        acc(RD, a, 32'h0, 4'hF, SUP, 32'hDFF0FF01, 1'b0);
        acc(WR, a, 32'h20004001, 4'hF, SUP, 32'h0, 1'b0);
        acc(RD, a, 32'h0, 4'hF, SUP, 32'h00004001, 1'b0);
        check("pin out", pull ? pulldown_enable_bits : slew_limit_bits, 32'h00004001);
        $display("test pin_field %h done", a);
    endtask : test_pin_field

    task automatic test_fixed_regs;
        acc(WR, `ADDR_IDENT, 32'hFFFFFFFF, 4'hF, SUP, 32'h0, 1'b0);
        acc(RD, `ADDR_IDENT, 32'h0, 4'hF, SUP, {16'h0, ID_VAL, REV_VAL}, 1'b0);
        acc(WR, `ADDR_TEST, 32'h0, 4'h3, SUP, 32'h0, 1'b0);
        acc(RD, `ADDR_TEST, 32'h0, 4'hF, SUP, 32'h0, 1'b0);
        check("test out", {16'h0, factory_test_reg}, 32'h0);
        $display("test fixed_regs done");
    endtask : test_fixed_regs

    // user transfers and an unmapped word are refused and change nothing
    task automatic test_refused;
        acc(WR, `ADDR_SLEW, 32'hFFFFFFFF, 4'hF, USR, 32'h0, 1'b1);
        acc(RD, `ADDR_PULL, 32'h0, 4'hF, USR, 32'h0, 1'b1);
        acc(WR, 12'h044, 32'hFFFFFFFF, 4'hF, SUP, 32'h0, 1'b1);
        acc(RD, `ADDR_SLEW, 32'h0, 4'hF, SUP, 32'h00004001, 1'b0);
        $display("test refused done");
    endtask : test_refused

    // reset in mid-run clears the pad controls at once
    task automatic test_mid_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check("slew out", slew_limit_bits, 32'h0);
        check("pull out", pulldown_enable_bits, 32'h0);
        presetn <= 1'b1;
        acc(RD, `ADDR_PULL, 32'h0, 4'hF, SUP, 32'h0, 1'b0);
        $display("test mid_reset done");
    endtask : test_mid_reset

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        presetn = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        test_reset_values();
        test_pin_field(`ADDR_SLEW, 1'b0);
        test_pin_field(`ADDR_PULL, 1'b1);
        test_fixed_regs();
        test_refused();
        test_mid_reset();
        end_sim();
    end

    // the tests need under a hundred cycles; this cuts a hang short
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        end_sim();
    end
endmodule : chip_pad_config_regs_tb_top

// ===== rtl/apb_access_decode.sv
`timescale 1ns/100ps
`include "pad_cfg_defs.svh"

module apb_access_decode (
    input wire pad_cfg_pkg::addr_t paddr,
    input wire pad_cfg_pkg::prot_t pprot,
    reg_access_if.decoder dec
);
    import pad_cfg_pkg::*;

    // full address compare; unaligned or unlisted addresses fall out as unmapped
    assign dec.hit_slew = (paddr == `ADDR_SLEW);
    assign dec.hit_pull = (paddr == `ADDR_PULL);
    assign dec.hit_test = (paddr == `ADDR_TEST);
    assign dec.hit_ident = (paddr == `ADDR_IDENT);
    assign dec.mapped = dec.hit_slew | dec.hit_pull | dec.hit_test | dec.hit_ident;
    // privileged transfers stand for supervisor mode
    assign dec.privileged = pprot[`PROT_PRIV_BIT];

endmodule : apb_access_decode

// ===== rtl/chip_pad_config_regs.sv
`timescale 1ns/100ps
`include "pad_cfg_defs.svh"

// Operation
// - One slew-limit bit per pin group, 0 normal and 1 limited, with bits 15..0 for the low pin groups.
// - Each pull-down bit other than the reserved 29 and 19..16 is read/write and a 1 enables the pull-down of its pin group.
// - Pull-down bits 31,30,28,27..20 and 15..0 drive pin groups while bits 29 and 19..16 are reserved.
// - Writes to reserved bits are dropped and the transfer still ends without an error.
// - The factory test register sits at index 0x0010 and exists only for manufacturing test.
// - The identification register at index 0x0012 is read-only and writes leave it unchanged.
// - The identification register holds an 8-bit fixed part number.
// - The identification register holds an 8-bit mask revision number.
// - The slew-limit field is read/write at index 0x0008, upper bits covering the remaining pin groups.
// - Only supervisor transfers act; a user transfer has no effect and ends with a transfer error.
module chip_pad_config_regs #(
    parameter logic [7:0] PART_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] PART_REV = 8'h01 // arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire pad_cfg_pkg::addr_t paddr,
    input wire pad_cfg_pkg::word_t pwdata,
    input wire pad_cfg_pkg::strb_t pstrb,
    input wire pad_cfg_pkg::prot_t pprot,
    output pad_cfg_pkg::word_t prdata,
    output logic pready,
    output logic pslverr,
    output pad_cfg_pkg::word_t slew_limit_bits,
    output pad_cfg_pkg::word_t pulldown_enable_bits,
    output logic [15:0] factory_test_reg
);
    import pad_cfg_pkg::*;

    access_state_t state_reg;
    access_state_t state_next;
    word_t prdata_reg;
    word_t prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic pslverr_next;
    word_t slew_q;
    word_t pull_q;
    logic [15:0] test_q;
    word_t ident_word;
    word_t read_word;
    logic setup_phase;
    logic commit;
    logic access_ok;
    logic write_ok;
    logic wen_slew;
    logic wen_pull;
    logic wen_test;
    logic reset_seen_reg;

    reg_access_if dec_if ();

    // address and privilege decode
    apb_access_decode u_decode (
        .paddr(paddr),
        .pprot(pprot),
        .dec(dec_if.decoder)
    );

    // transfer phases: the answer is prepared on the setup edge so the access phase ends at once
    assign setup_phase = psel && !penable && (state_reg == ST_IDLE);
    assign commit = psel && penable && pready_reg;

    assign access_ok = dec_if.privileged && dec_if.mapped;
    assign write_ok = commit && pwrite && access_ok;

    assign wen_slew = write_ok && dec_if.hit_slew;
    assign wen_pull = write_ok && dec_if.hit_pull;
    assign wen_test = write_ok && dec_if.hit_test;

    assign ident_word = {16'h0000, PART_ID, PART_REV};

    // read selection; anything refused reads as zero
    assign read_word = dec_if.hit_slew ? slew_q :
                       dec_if.hit_pull ? pull_q :
                       dec_if.hit_test ? {16'h0000, test_q} :
                       dec_if.hit_ident ? ident_word : 32'h00000000;

    // next answer values, taken only at the setup edge
    assign prdata_next = (access_ok && !pwrite) ? read_word : 32'h00000000;
    assign pslverr_next = !access_ok;

    // answer sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (setup_phase) begin
                    state_next = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                // a master that drops psel mid-transfer also frees the slave
                if (commit || !psel) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // answer registers: pready rises for exactly the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            pready_reg <= setup_phase;
            pslverr_reg <= setup_phase ? pslverr_next : 1'b0;
            prdata_reg <= setup_phase ? prdata_next : 32'h00000000;
        end
    end

    masked_cfg_reg #(
        .WIDTH(`PIN_WIDTH),
        .WMASK(`PIN_WMASK),
        .RESET(`PIN_RESET)
    ) u_slew (
        .pclk(pclk),
        .presetn(presetn),
        .wen(wen_slew),
        .wdata(pwdata),
        .wstrb(pstrb),
        .q_reg(slew_q)
    );

    masked_cfg_reg #(
        .WIDTH(`PIN_WIDTH),
        .WMASK(`PIN_WMASK),
        .RESET(`PIN_RESET)
    ) u_pull (
        .pclk(pclk),
        .presetn(presetn),
        .wen(wen_pull),
        .wdata(pwdata),
        .wstrb(pstrb),
        .q_reg(pull_q)
    );

    // test features unlocked; no bit is masked, so supervisor writes load every strobed byte of the 16 bits
    // the bits reach the pads unguarded; writing anything but zero is software's risk
    masked_cfg_reg #(
        .WIDTH(`TEST_WIDTH),
        .WMASK(`TEST_WMASK),
        .RESET(`TEST_RESET)
    ) u_test (
        .pclk(pclk),
        .presetn(presetn),
        .wen(wen_test),
        .wdata(pwdata[15:0]),
        .wstrb(pstrb[1:0]),
        .q_reg(test_q)
    );

    // outputs come straight from the flops above
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign slew_limit_bits = slew_q;
    assign pulldown_enable_bits = pull_q;
    assign factory_test_reg = test_q;

    // helper: high in the first cycle after reset is released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_seen_reg <= 1'b1;
        end else begin
            reset_seen_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_RESET_CLEAR: assert property (
        reset_seen_reg |-> (slew_limit_bits == 32'h00000000) && (pulldown_enable_bits == 32'h00000000)
            && (factory_test_reg == 16'h0000))
    else $error("pin or test bits not zero after reset");

    AST_SLEW_WRITE: assert property (
        (commit && pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_SLEW) && (pstrb == 4'hF))
            |=> (slew_limit_bits == ($past(pwdata) & `PIN_WMASK)))
    else $error("slew field did not take the written value");

    AST_SLEW_READ: assert property (
        (setup_phase && !pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_SLEW))
            |=> pready && !pslverr && (prdata == slew_limit_bits))
    else $error("slew field read back wrong");

    AST_PULL_WRITE: assert property (
        (commit && pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_PULL) && (pstrb == 4'hF))
            |=> (pulldown_enable_bits == ($past(pwdata) & `PIN_WMASK)))
    else $error("pull-down field did not take the written value");

    AST_PULL_RESERVED: assert property (
        (pulldown_enable_bits[29] == 1'b0) && (pulldown_enable_bits[19:16] == 4'h0))
    else $error("reserved pull-down bit set");

    AST_NO_FAULT_PRIV: assert property (
        (setup_phase && pprot[`PROT_PRIV_BIT] && ((paddr == `ADDR_SLEW) || (paddr == `ADDR_PULL)
            || (paddr == `ADDR_IDENT))) |=> pready && !pslverr ##1 !pready)
    else $error("mapped supervisor access faulted");

    AST_TEST_WRITE: assert property (
        (commit && pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_TEST) && (pstrb[1:0] == 2'h3))
            |=> (factory_test_reg == $past(pwdata[15:0])))
    else $error("factory test register did not take the written value");

    AST_IDENT_WRITE: assert property (
        (commit && pwrite && (paddr == `ADDR_IDENT))
            |=> $stable(slew_limit_bits) && $stable(pulldown_enable_bits) && $stable(factory_test_reg))
    else $error("write to identification changed a register");

    AST_IDENT_READ: assert property (
        (setup_phase && !pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_IDENT))
            |=> (prdata[15:`IDENT_PART_LSB] == PART_ID) && (prdata[7:0] == PART_REV))
    else $error("identification read wrong");

    // user access faults with no effect
    AST_USER_FAULT: assert property (
        (setup_phase && !pprot[`PROT_PRIV_BIT]) |=> pready && pslverr && (prdata == 32'h00000000)
            ##1 $stable(slew_limit_bits) && $stable(pulldown_enable_bits) && $stable(factory_test_reg))
    else $error("user access not refused");

    // helper: the listed words, worked out apart from the decoder so that a decode slip
    // shows up here instead of being mirrored by the logic it is meant to check
    logic addr_listed;
    assign addr_listed = (paddr == `ADDR_SLEW) || (paddr == `ADDR_PULL) || (paddr == `ADDR_TEST)
        || (paddr == `ADDR_IDENT);

    AST_READY_AFTER_SETUP: assert property (
        setup_phase |=> pready)
    else $error("setup not answered in the next cycle");

    AST_READY_PULSE: assert property (
        pready |=> !pready)
    else $error("ready held past one cycle");

    AST_ERR_WITH_READY: assert property (
        pslverr |-> pready)
    else $error("error flag without ready");

    AST_IDLE_DATA_ZERO: assert property (
        !pready |-> (prdata == 32'h00000000))
    else $error("read data shown outside the answer cycle");

    AST_UNMAPPED_FAULT: assert property (
        (setup_phase && pprot[`PROT_PRIV_BIT] && !addr_listed) |=> pready && pslverr
            ##1 $stable(slew_limit_bits) && $stable(pulldown_enable_bits) && $stable(factory_test_reg))
    else $error("unlisted word not refused");

    AST_SLEW_RESERVED: assert property (
        (slew_limit_bits[29] == 1'b0) && (slew_limit_bits[19:16] == 4'h0))
    else $error("reserved slew bit set");

    AST_SLEW_LANE_KEEP: assert property (
        (commit && pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_SLEW) && !pstrb[3])
            |=> (slew_limit_bits[31:24] == $past(slew_limit_bits[31:24])))
    else $error("slew byte changed without its strobe");

    AST_PULL_LANE_KEEP: assert property (
        (commit && pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_PULL) && !pstrb[3])
            |=> (pulldown_enable_bits[31:24] == $past(pulldown_enable_bits[31:24])))
    else $error("pull-down byte changed without its strobe");

    AST_PULL_READ: assert property (
        (setup_phase && !pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_PULL))
            |=> pready && !pslverr && (prdata == pulldown_enable_bits))
    else $error("pull-down field read back wrong");

    AST_TEST_READ: assert property (
        (setup_phase && !pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_TEST))
            |=> pready && !pslverr && (prdata == {16'h0000, factory_test_reg}))
    else $error("factory test register read back wrong");

    AST_TEST_WRITE_OK: assert property (
        (setup_phase && pwrite && pprot[`PROT_PRIV_BIT] && (paddr == `ADDR_TEST))
            |=> pready && !pslverr)
    else $error("supervisor write to the factory test register faulted");

    // main scenarios
    COV_SLEW_WRITE: cover property (wen_slew ##1 (slew_limit_bits != 32'h00000000));
    COV_USER_FAULT: cover property (commit && pslverr);
    COV_IDENT_READ: cover property (commit && !pwrite && dec_if.hit_ident);
    COV_TEST_WRITE: cover property (wen_test);
    COV_BACK_TO_BACK: cover property (commit ##1 setup_phase);

endmodule : chip_pad_config_regs

// ===== rtl/masked_cfg_reg.sv
`timescale 1ns/100ps

module masked_cfg_reg #(
    parameter int WIDTH = 32,
    parameter logic [WIDTH-1:0] WMASK = '1,
    parameter logic [WIDTH-1:0] RESET = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wen,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH/8-1:0] wstrb,
    output logic [WIDTH-1:0] q_reg
);
    import pad_cfg_pkg::*;

    genvar g;
    // one byte lane per strobe; masked bits always load zero so reserved bits stay 0
    generate
        for (g = 0; g < WIDTH / 8; g = g + 1) begin : g_lane
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    q_reg[g*8 +: 8] <= RESET[g*8 +: 8];
                end else if (wen && wstrb[g]) begin
                    q_reg[g*8 +: 8] <= wdata[g*8 +: 8] & WMASK[g*8 +: 8];
                end
            end
        end
    endgenerate

endmodule : masked_cfg_reg

// ===== rtl/pad_cfg_defs.svh
`ifndef PAD_CFG_DEFS_SVH
`define PAD_CFG_DEFS_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_SLEW 10'h008
`define IDX_PULL 10'h00C
`define IDX_TEST 10'h010
`define IDX_IDENT 10'h012
`define ADDR_SLEW {`IDX_SLEW, 2'b00}
`define ADDR_PULL {`IDX_PULL, 2'b00}
`define ADDR_TEST {`IDX_TEST, 2'b00}
`define ADDR_IDENT {`IDX_IDENT, 2'b00}

// writable bits: bit 29 and bits 19..16 are reserved in both pin fields
`define PIN_WMASK 32'hDFF0FFFF
`define TEST_WMASK 16'hFFFF

// reset values
`define PIN_RESET 32'h00000000
`define TEST_RESET 16'h0000

// field widths and positions
`define PIN_WIDTH 32
`define TEST_WIDTH 16
`define IDENT_PART_LSB 8
`define PROT_PRIV_BIT 0

`endif

// ===== rtl/pad_cfg_pkg.sv
package pad_cfg_pkg;

    // bus data word and address
    typedef logic [31:0] word_t;
    typedef logic [11:0] addr_t;
    typedef logic [3:0] strb_t;
    typedef logic [2:0] prot_t;

    // per-transfer answer sequencing
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ANSWER = 2'b01
    } access_state_t;

endpackage : pad_cfg_pkg

// ===== rtl/reg_access_if.sv
`timescale 1ns/100ps

// decode results passed from the address decoder to the register bank
interface reg_access_if;
    logic hit_slew;
    logic hit_pull;
    logic hit_test;
    logic hit_ident;
    logic mapped;
    logic privileged;

    modport decoder (
        output hit_slew,
        output hit_pull,
        output hit_test,
        output hit_ident,
        output mapped,
        output privileged
    );
    modport bank (
        input hit_slew,
        input hit_pull,
        input hit_test,
        input hit_ident,
        input mapped,
        input privileged
    );
endinterface : reg_access_if
